// ==== src/thr_trig_detector.sv ====
// threshold trigger detector: feature test, debounce, hysteresis window,
// trigger, strobe, delayed waveform, snippet stream, timestamps, irq
// assumes mclk is the sample clock and ch_in carries one new sample a cycle
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - four channels come in; one selected channel is tested, all are kept
// - test modes: above, below, between, outside, rising, falling
// - feature output is high on each sample where the test holds
// - with debounce the test must hold three samples in a row
// - hysteresis: false over pre-window, true from crossing over post-window
// - a pass pulses the trigger for exactly one sample, once per pass
// - strobe rises with the trigger and stays high for range samples
// - delayed output is input delayed by range+offset, plus post if hysteresis
// - with the enable control present, trigger and strobe wait for enable
// - with the enable control hidden, trigger and strobe are always enabled
// - feature edges and triggers can be timestamped as events
// - with capture selected a pass streams all channels over the window
module thr_trig_detector
  import thr_trig_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire samples_s          ch_in,
  output logic                   feature_out,
  output logic                   trigger_out,
  output logic                   strobe_out,
  output sample_t                delayed_waveform_out,
  output logic                   snip_valid,
  output samples_s               snip_data,
  output logic                   irq
);
  ctrl_s                    ctrl_r,    ctrl_nxt;
  sample_t                  thr_hi_r,  thr_hi_nxt;
  sample_t                  thr_lo_r,  thr_lo_nxt;
  logic [MARK_W-1:0]        range_r,   range_nxt;
  logic [MARK_W-1:0]        offset_r,  offset_nxt;
  logic [MARK_W-1:0]        pre_r,     pre_nxt;
  logic [MARK_W-1:0]        post_r,    post_nxt;
  logic [ST_W-1:0]          status_r,  status_nxt;
  logic [ST_W-1:0]          mask_r,    mask_nxt;
  logic [TS_W-1:0]          ts_r,      ts_nxt;
  logic [TS_W-1:0]          ts_feat_r, ts_feat_nxt;
  logic [TS_W-1:0]          ts_trig_r, ts_trig_nxt;
  logic [31:0]              prdata_nxt;
  logic                     pready_nxt, pslverr_nxt, irq_nxt;
  logic                     wr_go, rd_go, mapped;

  sample_t                  cur_c, prev_r, prev_nxt;
  logic                     raw_c, feat_c, cross_c;
  logic [1:0]               db_r,  db_nxt;
  logic [MARK_W-1:0]        frun_r, frun_nxt;
  logic [MARK_W-1:0]        hcnt_r, hcnt_nxt;
  hyst_state_e              hst_r, hst_nxt;
  logic                     pass_c, gate_en;
  logic                     trig_nxt, strobe_nxt, snipv_nxt, feat_nxt;
  logic [MARK_W-1:0]        scnt_r, scnt_nxt;

  samples_s                 mem [DLY_DEPTH];
  logic [DLY_W-1:0]         wp_r, wp_nxt, rd_idx, dly_c;
  samples_s                 rd_word;

  // apb slave: one setup cycle, answer ready in the access cycle
  assign wr_go = psel & penable & pready & pwrite;
  assign rd_go = psel & penable & pready & ~pwrite;

  always_comb
  begin
    mapped = (paddr[1:0] == 2'h0) && (paddr <= OFF_LIVE);
    unique case (paddr)
      OFF_CTRL:    prdata_nxt = {20'h0, ctrl_r};
      OFF_THR_HI:  prdata_nxt = {{16{thr_hi_r[15]}}, thr_hi_r};
      OFF_THR_LO:  prdata_nxt = {{16{thr_lo_r[15]}}, thr_lo_r};
      OFF_RANGE:   prdata_nxt = {27'h0, range_r};
      OFF_OFFSET:  prdata_nxt = {27'h0, offset_r};
      OFF_PRE:     prdata_nxt = {27'h0, pre_r};
      OFF_POST:    prdata_nxt = {27'h0, post_r};
      OFF_STATUS:  prdata_nxt = {28'h0, status_r};
      OFF_MASK:    prdata_nxt = {28'h0, mask_r};
      OFF_TS_FEAT: prdata_nxt = ts_feat_r;
      OFF_TS_TRIG: prdata_nxt = ts_trig_r;
      OFF_LIVE:    prdata_nxt = {29'h0, trigger_out, strobe_out, feature_out};
      default:     prdata_nxt = 32'h0;
    endcase
    if (!(psel & ~penable))
      prdata_nxt = prdata;
    pready_nxt  = psel & ~penable;
    pslverr_nxt = psel & ~penable & ~mapped;
    ctrl_nxt    = ctrl_r;
    thr_hi_nxt  = thr_hi_r;
    thr_lo_nxt  = thr_lo_r;
    range_nxt   = range_r;
    offset_nxt  = offset_r;
    pre_nxt     = pre_r;
    post_nxt    = post_r;
    mask_nxt    = mask_r;
    if (wr_go)
    begin
      unique case (paddr)
        OFF_CTRL:   ctrl_nxt   = ctrl_s'(pwdata[CTRL_W-1:0]);
        OFF_THR_HI: thr_hi_nxt = pwdata[SAMPLE_W-1:0];
        OFF_THR_LO: thr_lo_nxt = pwdata[SAMPLE_W-1:0];
        OFF_RANGE:  range_nxt  = pwdata[MARK_W-1:0];
        OFF_OFFSET: offset_nxt = pwdata[MARK_W-1:0];
        OFF_PRE:    pre_nxt    = pwdata[MARK_W-1:0];
        OFF_POST:   post_nxt   = pwdata[MARK_W-1:0];
        OFF_MASK:   mask_nxt   = pwdata[ST_W-1:0];
        default:    ;
      endcase
    end
    // events: set wins over the clear that a status read does
    status_nxt = status_r;
    if (rd_go && paddr == OFF_STATUS)
      status_nxt = '0;
    ts_nxt      = ts_r + 32'h1;
    ts_feat_nxt = ts_feat_r;
    ts_trig_nxt = ts_trig_r;
    if (ctrl_r.rec_feat && feat_c != feature_out)
    begin
      ts_feat_nxt = ts_r;
      status_nxt[feat_c ? ST_FEAT_RISE : ST_FEAT_FALL] = 1'b1;
    end
    if (ctrl_r.rec_trig && trig_nxt)
    begin
      ts_trig_nxt = ts_r;
      status_nxt[ST_TRIG] = 1'b1;
    end
    if (snip_valid && !snipv_nxt)
      status_nxt[ST_SNIP_DONE] = 1'b1;
    irq_nxt = |(status_nxt & mask_nxt);
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ctrl_r    <= ctrl_s'(CTRL_RST);
      thr_hi_r  <= THR_HI_RST;
      thr_lo_r  <= THR_LO_RST;
      range_r   <= RANGE_RST;
      offset_r  <= MARK_RST;
      pre_r     <= MARK_RST;
      post_r    <= MARK_RST;
      mask_r    <= '0;
      status_r  <= '0;
      ts_r      <= '0;
      ts_feat_r <= '0;
      ts_trig_r <= '0;
      prdata    <= '0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      irq       <= 1'b0;
    end
    else
    begin
      ctrl_r    <= ctrl_nxt;
      thr_hi_r  <= thr_hi_nxt;
      thr_lo_r  <= thr_lo_nxt;
      range_r   <= range_nxt;
      offset_r  <= offset_nxt;
      pre_r     <= pre_nxt;
      post_r    <= post_nxt;
      mask_r    <= mask_nxt;
      status_r  <= status_nxt;
      ts_r      <= ts_nxt;
      ts_feat_r <= ts_feat_nxt;
      ts_trig_r <= ts_trig_nxt;
      prdata    <= prdata_nxt;
      pready    <= pready_nxt;
      pslverr   <= pslverr_nxt;
      irq       <= irq_nxt;
    end
  end

  // feature test, debounce, hysteresis, trigger and strobe
  assign cur_c   = ch_in.ch[ctrl_r.ch_sel];
  assign gate_en = ~ctrl_r.enable_present | ctrl_r.sw_enable;

  always_comb
  begin
    unique case (ctrl_r.mode)
      FEAT_ABOVE:   raw_c = cur_c > thr_hi_r;
      FEAT_BELOW:   raw_c = cur_c < thr_hi_r;
      FEAT_BETWEEN: raw_c = (cur_c < thr_hi_r) && (cur_c > thr_lo_r);
      FEAT_OUTSIDE: raw_c = (cur_c > thr_hi_r) || (cur_c < thr_lo_r);
      FEAT_RISING:  raw_c = cur_c > prev_r;
      FEAT_FALLING: raw_c = cur_c < prev_r;
      default:      raw_c = 1'b0;
    endcase
    prev_nxt = cur_c;
    db_nxt   = raw_c ? ((db_r == DEBOUNCE_PRE) ? db_r : db_r + 2'h1) : 2'h0;
    feat_c   = ctrl_r.debounce_en ? (raw_c && db_r == DEBOUNCE_PRE)
                                  : raw_c;
    feat_nxt = feat_c;
    cross_c  = feat_c & ~feature_out;
    frun_nxt = feat_c ? '0 : ((&frun_r) ? frun_r : frun_r + 5'h1);
    hst_nxt  = hst_r;
    hcnt_nxt = hcnt_r;
    pass_c   = 1'b0;
    unique case (hst_r)
      HY_IDLE:
        if (cross_c)
        begin
          if (!ctrl_r.hyst_en)
            pass_c = 1'b1;
          else if (frun_r >= pre_r)
          begin
            if (post_r == '0)
              pass_c = 1'b1;
            else
            begin
              hst_nxt  = HY_CHECK;
              hcnt_nxt = '0;
            end
          end
        end
      HY_CHECK:
        if (!feat_c)
          hst_nxt = HY_IDLE;
        else if (hcnt_r + 5'h1 == post_r)
        begin
          pass_c  = 1'b1;
          hst_nxt = HY_IDLE;
        end
        else
          hcnt_nxt = hcnt_r + 5'h1;
    endcase
    trig_nxt = pass_c & gate_en;
    if (!gate_en)
      scnt_nxt = '0;
    else if (trig_nxt)
      scnt_nxt = range_r;
    else if (scnt_r != '0)
      scnt_nxt = scnt_r - 5'h1;
    else
      scnt_nxt = '0;
    strobe_nxt = scnt_nxt != '0;
    snipv_nxt  = strobe_nxt & ctrl_r.capture_en;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      prev_r      <= '0;
      db_r        <= '0;
      frun_r      <= '0;
      hcnt_r      <= '0;
      hst_r       <= HY_IDLE;
      scnt_r      <= '0;
      feature_out <= 1'b0;
      trigger_out <= 1'b0;
      strobe_out  <= 1'b0;
      snip_valid  <= 1'b0;
    end
    else
    begin
      prev_r      <= prev_nxt;
      db_r        <= db_nxt;
      frun_r      <= frun_nxt;
      hcnt_r      <= hcnt_nxt;
      hst_r       <= hst_nxt;
      scnt_r      <= scnt_nxt;
      feature_out <= feat_nxt;
      trigger_out <= trig_nxt;
      strobe_out  <= strobe_nxt;
      snip_valid  <= snipv_nxt;
    end
  end

  // delay line holding all channels so the snippet lines up with strobe
  always_comb
  begin
    dly_c = DLY_W'(range_r) + DLY_W'(offset_r)
          + (ctrl_r.hyst_en ? DLY_W'(post_r) : 7'h0);
    rd_idx  = wp_r - dly_c;
    rd_word = (dly_c == '0) ? ch_in : mem[rd_idx];
    wp_nxt  = wp_r + 7'h1;
  end

  always_ff @(posedge mclk)
  begin
    mem[wp_r] <= ch_in;
    if (reset)
    begin
      wp_r                 <= '0;
      delayed_waveform_out <= '0;
      snip_data            <= '0;
    end
    else
    begin
      wp_r                 <= wp_nxt;
      delayed_waveform_out <= rd_word.ch[ctrl_r.ch_sel];
      snip_data            <= rd_word;
    end
  end

  // checks
  logic [MARK_W:0] hc_r;
  always_ff @(posedge mclk)
  begin
    if (reset)
      hc_r <= '0;
    else if (trigger_out)
      hc_r <= 6'h1;
    else if (strobe_out)
      hc_r <= hc_r + 6'h1;
  end

  a_trig_one_pulse: assert property (@(posedge mclk) disable iff (reset)
    trigger_out |=> !trigger_out) else $error("trigger longer than one sample");
  a_strobe_start: assert property (@(posedge mclk) disable iff (reset)
    trigger_out && range_r != '0 |-> strobe_out) else $error("strobe missed trigger");
  a_strobe_length: assert property (@(posedge mclk) disable iff (reset)
    $fell(strobe_out) && gate_en && $stable(range_r) |-> hc_r == {1'b0, range_r})
    else $error("strobe length differs from range");
  a_gate_blocks: assert property (@(posedge mclk) disable iff (reset)
    !gate_en |=> !trigger_out && !strobe_out) else $error("output while disabled");
  a_feat_above: assert property (@(posedge mclk) disable iff (reset)
    ctrl_r.mode == FEAT_ABOVE && !ctrl_r.debounce_en && cur_c > thr_hi_r
    |=> feature_out) else $error("above feature not reported");
  a_debounce_three: assert property (@(posedge mclk) disable iff (reset)
    $rose(feature_out) && $past(ctrl_r.debounce_en)
    |-> $past(raw_c, 1) && $past(raw_c, 2) && $past(raw_c, 3))
    else $error("debounced feature too early");
  a_rising_prev: assert property (@(posedge mclk) disable iff (reset)
    ctrl_r.mode == FEAT_RISING && !ctrl_r.debounce_en && cur_c > prev_r
    |=> feature_out) else $error("rising feature not reported");
  a_delay_two: assert property (@(posedge mclk) disable iff (reset)
    dly_c == 7'h2 && ctrl_r.ch_sel == $past(ctrl_r.ch_sel, 2)
    && $past(reset, 2) == 1'b0
    |=> delayed_waveform_out == $past(cur_c, 3)) else $error("delay mismatch");
  a_trig_stamp: assert property (@(posedge mclk) disable iff (reset)
    trigger_out && $past(ctrl_r.rec_trig) |-> status_r[ST_TRIG])
    else $error("trigger event not recorded");
  a_hyst_pre: assert property (@(posedge mclk) disable iff (reset)
    trigger_out && $past(ctrl_r.hyst_en) && $past(post_r) == '0
    |-> $past(frun_r) >= $past(pre_r)) else $error("pre window violated");

  c_trigger: cover property (@(posedge mclk) disable iff (reset) trigger_out);
  c_hyst_pass: cover property (@(posedge mclk) disable iff (reset)
    hst_r == HY_CHECK && pass_c);
  c_snippet: cover property (@(posedge mclk) disable iff (reset) $fell(snip_valid));
  c_irq: cover property (@(posedge mclk) disable iff (reset) irq);
endmodule // thr_trig_detector

`default_nettype wire

// ==== src/thr_trig_pkg.sv ====
// constants, types and register map of the threshold trigger detector
// assumes one sample per mclk cycle and an apb master on the register side
package thr_trig_pkg;
  localparam int unsigned SAMPLE_W  = 16;
  localparam int unsigned N_CH      = 4;
  localparam int unsigned MARK_W    = 5;
  localparam int unsigned DLY_W     = 7;
  localparam int unsigned DLY_DEPTH = 128;
  localparam int unsigned TS_W      = 32;
  localparam logic [1:0]  DEBOUNCE_PRE = 2'h2;

  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_THR_HI  = 8'h04;
  localparam logic [7:0] OFF_THR_LO  = 8'h08;
  localparam logic [7:0] OFF_RANGE   = 8'h0c;
  localparam logic [7:0] OFF_OFFSET  = 8'h10;
  localparam logic [7:0] OFF_PRE     = 8'h14;
  localparam logic [7:0] OFF_POST    = 8'h18;
  localparam logic [7:0] OFF_STATUS  = 8'h1c;
  localparam logic [7:0] OFF_MASK    = 8'h20;
  localparam logic [7:0] OFF_TS_FEAT = 8'h24;
  localparam logic [7:0] OFF_TS_TRIG = 8'h28;
  localparam logic [7:0] OFF_LIVE    = 8'h2c;

  localparam int unsigned ST_FEAT_RISE = 0;
  localparam int unsigned ST_FEAT_FALL = 1;
  localparam int unsigned ST_TRIG      = 2;
  localparam int unsigned ST_SNIP_DONE = 3;
  localparam int unsigned ST_W         = 4;

  typedef enum logic [2:0]
  {
    FEAT_ABOVE   = 3'h0,
    FEAT_BELOW   = 3'h1,
    FEAT_BETWEEN = 3'h2,
    FEAT_OUTSIDE = 3'h3,
    FEAT_RISING  = 3'h4,
    FEAT_FALLING = 3'h5
  } feat_mode_e;

  typedef enum logic [0:0]
  {
    HY_IDLE  = 1'h0,
    HY_CHECK = 1'h1
  } hyst_state_e;

  typedef logic signed [SAMPLE_W-1:0] sample_t;

  typedef struct packed {
    sample_t [N_CH-1:0] ch;
  } samples_s;

  typedef struct packed {
    logic       sw_enable;
    logic       capture_en;
    logic       rec_trig;
    logic       rec_feat;
    logic       enable_present;
    logic       hyst_en;
    logic       debounce_en;
    logic [1:0] ch_sel;
    feat_mode_e mode;
  } ctrl_s;

  localparam int unsigned CTRL_W = 12;
  localparam logic [CTRL_W-1:0] CTRL_RST   = 12'h000;
  localparam sample_t           THR_HI_RST = 16'sh0100;
  localparam sample_t           THR_LO_RST = -16'sh0100;
  localparam logic [MARK_W-1:0] RANGE_RST  = 5'h08;
  localparam logic [MARK_W-1:0] MARK_RST   = 5'h00;
endpackage

// ==== dv/sample_source.sv ====
// upstream sample source: four channels, one new sample per mclk
// assumes the bench picks the selected channel and its value
`timescale 1ns/1ns
`default_nettype none
module sample_source
  import thr_trig_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       quiet,
  input  wire logic [1:0] sel,
  input  wire sample_t    sel_val,
  output var  samples_s   ch_out
);
  int seed = 38091;

  initial ch_out = '0;

  // other channels carry noise; quiet copies the value to all of them
  always @(posedge mclk)
  begin
    for (int k = 0; k < N_CH; k++)
      ch_out.ch[k] <= (quiet || k == sel) ? sel_val
                                          : sample_t'($random(seed));
  end
endmodule // sample_source
`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking bench of the threshold trigger detector
// assumes the sample source model feeds ch_in and apb reaches registers
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import thr_trig_pkg::*;
;
  localparam sample_t MARK = 16'sh7abc;
  localparam logic [7:0] RA [10] = '{OFF_CTRL, OFF_THR_HI, OFF_THR_LO,
    OFF_RANGE, OFF_OFFSET, OFF_PRE, OFF_POST, OFF_MASK, 8'h30, 8'h02};
  localparam logic [32:0] RV [10] = '{33'h0, 33'h100, 33'hffffff00,
    33'h8, 33'h0, 33'h0, 33'h0, 33'h0, 33'h100000000, 33'h100000000};
  logic        mclk = 0, reset = 1, quiet = 1, cap = 0;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [1:0]  sel = '0;
  logic        pready, pslverr, feature_out, trigger_out;
  logic        strobe_out, snip_valid, irq;
  sample_t     sel_val = '0, dly, fv;
  samples_s    ch_in, snip;
  logic [65:0] apb_q[$], a;
  int          trig_q[$], str_q[$], dly_q[$];
  int          cyc = 0, s_len = 0, fail_count = 0, samples_checked = 0;

  always #25 mclk = ~mclk;

  sample_source u_src (.mclk(mclk), .quiet(quiet), .sel(sel),
    .sel_val(sel_val), .ch_out(ch_in));

  thr_trig_detector u_dut (.mclk(mclk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch_in(ch_in),
    .feature_out(feature_out), .trigger_out(trigger_out),
    .strobe_out(strobe_out), .delayed_waveform_out(dly),
    .snip_valid(snip_valid), .snip_data(snip), .irq(irq));

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic take(ref int q[$], input int got);
    if (q.size() == 0)
      chk(got, '1);
    else
      chk(got, q.pop_front());
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // one apb transfer; the expected answer is noted for the watcher
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d, input logic [32:0] e, m);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    apb_q.push_back({m, e});
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d, 33'h0, 33'h100000000);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [32:0] e, m);
    apb(1'b0, ad, 32'h0, e, m);
  endtask

  // all channels equal while the channel select moves
  task automatic set_ctrl(input logic [11:0] v);
    quiet <= 1'b1;
    sel <= v[4:3];
    wr(OFF_CTRL, {20'h0, v});
    cap = v[10];
    repeat (2) @(posedge mclk);
    quiet <= 1'b0;
  endtask

  task automatic run_pat(input sample_t f, t, input int nt, ex,
                         input bit hit, input int w);
    int c;
    sel_val <= f;
    repeat (6) @(posedge mclk);
    sel_val <= t;
    c = cyc;
    if (hit)
      trig_q.push_back(c + 3 + ex);
    if (hit && w > 0)
      str_q.push_back(w);
    repeat (nt) @(posedge mclk);
    sel_val <= f;
    repeat (w + 8) @(posedge mclk);
  endtask

  task automatic mark(input int d);
    int c;
    @(posedge mclk);
    sel_val <= MARK;
    quiet <= 1'b1;
    c = cyc;
    dly_q.push_back(c + 3 + d);
    @(posedge mclk);
    sel_val <= '0;
    quiet <= 1'b0;
    repeat (d + 8) @(posedge mclk);
  endtask

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      fail_count++;
      complete_run();
    end
    if (reset === 1'b0)
    begin
      if (psel && penable && pready === 1'b1)
      begin
        a = apb_q.pop_front();
        chk({pslverr, prdata} & a[65:33], a[32:0]);
      end
      if (trigger_out === 1'b1)
      begin
        take(trig_q, cyc);
        chk(feature_out, 1'b1);
      end
      if (dly === MARK)
      begin
        take(dly_q, cyc);
        chk(snip === {N_CH{MARK}}, 1'b1);
      end
      if (strobe_out === 1'b1)
        s_len = s_len + 1;
      else if (s_len != 0)
      begin
        take(str_q, s_len);
        s_len = 0;
      end
      chk(snip_valid, strobe_out & cap);
    end
  end

  initial
  begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 10; i++)
      rd(RA[i], RV[i], 33'h1ffffffff);
    $display("test register defaults done");
    for (int m = 0; m < 6; m++)
    begin
      fv = m inside {1, 2, 5} ? 16'sh0200 : 16'sh0000;
      // park the idle value under a gated mode so no stray pass fires
      set_ctrl(12'h080);
      sel_val <= fv;
      wr(OFF_RANGE, m + 2);
      set_ctrl(12'h400 | 12'(m % 4) << 3 | 12'(m));
      run_pat(fv, 16'sh0200 - fv, 12, 0, 1'b1, m + 2);
    end
    $display("test modes done");
    set_ctrl(12'h080);
    sel_val <= '0;
    wr(OFF_RANGE, 32'h3);
    set_ctrl(12'h020);
    run_pat(16'sh0, 16'sh0200, 2, 0, 1'b0, 0);
    run_pat(16'sh0, 16'sh0200, 12, 2, 1'b1, 3);
    $display("test debounce done");
    wr(OFF_PRE, 32'h3);
    set_ctrl(12'h040);
    run_pat(16'sh0, 16'sh0200, 12, 0, 1'b1, 3);
    wr(OFF_POST, 32'h2);
    run_pat(16'sh0, 16'sh0200, 1, 0, 1'b0, 0);
    run_pat(16'sh0, 16'sh0200, 12, 2, 1'b1, 3);
    $display("test hysteresis done");
    wr(OFF_RANGE, 32'h4);
    wr(OFF_OFFSET, 32'h5);
    set_ctrl(12'h080);
    mark(9);
    set_ctrl(12'h0c0);
    mark(11);
    $display("test delay done");
    wr(OFF_RANGE, 32'h0);
    set_ctrl(12'h080);
    run_pat(16'sh0, 16'sh0200, 12, 0, 1'b0, 0);
    set_ctrl(12'h880);
    run_pat(16'sh0, 16'sh0200, 12, 0, 1'b1, 0);
    $display("test enable done");
    set_ctrl(12'h300);
    run_pat(16'sh0, 16'sh0200, 12, 0, 1'b1, 0);
    chk(irq, 1'b0);
    wr(OFF_MASK, 32'h4);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b1);
    rd(OFF_STATUS, 33'h7, 33'h100000007);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b0);
    rd(OFF_STATUS, 33'h0, 33'h100000004);
    $display("test interrupt done");
    repeat (2) @(posedge mclk);
    // every noted expectation must have been met by now
    chk(trig_q.size() + str_q.size() + dly_q.size() + apb_q.size(), 0);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
